// ---- shared/etc_cfg.svh ----
// Offsets, field positions, reset values and source codes of the block
`ifndef ETC_CFG_SVH
`define ETC_CFG_SVH

`define ETC_CTRL_OFS 8'h00
`define ETC_ISTAT_OFS 8'h01
`define ETC_IMASK_OFS 8'h02

`define ETC_E1_MODE_BIT 15
`define ETC_E1_POL_BIT 14
`define ETC_E1_SEL_LSB 10
`define ETC_E2_STAT_BIT 9
`define ETC_E1_STAT_BIT 8
`define ETC_E2_MODE_BIT 7
`define ETC_E2_POL_BIT 6
`define ETC_E2_SEL_LSB 2

`define ETC_CTRL_RST 16'h0000
`define ETC_CFG_MASK 16'hFCFC
`define ETC_INT_RST 2'h0

`define ETC_SRC_TIMER 4'h0
`define ETC_SRC_OC 4'h1
`define ETC_SRC_TRIG_A 4'h2
`define ETC_SRC_TRIG_B 4'h3
`define ETC_SRC_CMP 4'h4
`define ETC_E1_MAX_SEL 4'h3
`define ETC_E2_MAX_SEL 4'h4
`define ETC_NSRC 5

`endif

// ---- shared/etc_pkg.sv ----
// Types shared by the edge trigger control modules
package etc_pkg;
  typedef logic [7:0] etc_addr_t;
  typedef logic [15:0] etc_data_t;
  typedef logic [3:0] etc_sel_t;
  typedef logic [1:0] etc_int_t;
endpackage

// ---- shared/etc_if.sv ----
// Configuration, sources and event of one edge channel
`timescale 1ns/1ps
`include "etc_cfg.svh"

interface etc_if;
  import etc_pkg::*;
  logic mode;
  logic pol;
  etc_sel_t sel;
  logic [`ETC_NSRC-1:0] src;
  logic evt;
  modport ctl (output mode, output pol, output sel, output src, input evt);
  modport cond (input mode, input pol, input sel, input src, output evt);
endinterface

// ---- rtl/etc_sync2.sv ----
// Two-stage synchroniser for asynchronous trigger pins
`timescale 1ns/1ps

module etc_sync2 #(
  parameter int W = 2
) (
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [W-1:0] d, // Asynchronous levels
  output logic [W-1:0] q // Synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ---- rtl/etc_edge_cond.sv ----
// Source selection and edge or level conditioning of one edge channel
`timescale 1ns/1ps
`include "etc_cfg.svh"

module etc_edge_cond #(
  parameter logic [3:0] MAX_SEL = `ETC_E1_MAX_SEL
) (
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  etc_if.cond b // Channel configuration, sources and event
);
  import etc_pkg::*;

  logic [`ETC_NSRC-1:0] prv_q;
  logic evt_q;
  logic cur;
  logic prv;
  logic valid;

  // Guarded so a reserved code never indexes past the source vector
  function automatic logic pick(input logic [`ETC_NSRC-1:0] v,
                                input etc_sel_t s);
    pick = (s <= `ETC_SRC_CMP) ? v[s[2:0]] : 1'b0;
  endfunction

  // History kept per source, so reselecting gives no false edge
  assign valid = (b.sel <= MAX_SEL);
  assign cur = pick(b.src, b.sel);
  assign prv = pick(prv_q, b.sel);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prv_q <= '0;
    else
      prv_q <= b.src;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      evt_q <= 1'b0;
    else if (!valid)
      evt_q <= 1'b0;
    else if (b.mode)
      evt_q <= b.pol ? (cur & ~prv) : (~cur & prv);
    else
      evt_q <= (cur == b.pol);
  end

  assign b.evt = evt_q;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_POS_EDGE:
    assert property (b.mode && b.pol && valid && cur && !prv |=> b.evt)
      else $error("rising edge on selected source gave no event");
  AST_NEG_EDGE:
    assert property (b.mode && !b.pol && valid && !cur && prv |=> b.evt)
      else $error("falling edge on selected source gave no event");
  AST_EDGE_STEADY:
    assert property (b.mode && valid && cur == prv |=> !b.evt)
      else $error("edge mode raised event on a steady source");
  AST_LEVEL:
    assert property (!b.mode && valid |=> b.evt == $past(cur == b.pol))
      else $error("level mode event does not follow source level");
  AST_RESERVED:
    assert property (b.sel > MAX_SEL |=> !b.evt)
      else $error("reserved source code produced an event");
endmodule

// ---- rtl/etc_top.sv ----
// Edge trigger control: register, edge conditioning, status and interrupt
//
// Summary of operation
// - Edge one bit 15: 1 edge, 0 level.
// - Edge one bit 14: 1 rising, 0 falling.
// - Edge one source bits 13-10, high codes reserved.
// - Edge two status bit 9, set or written.
// - Edge one status bit 8, set or written.
// - Edge two mode bit 7, polarity bit 6.
// - Edge two source bits 5-2, code 0100 comparator.
`timescale 1ns/1ps
`include "etc_cfg.svh"

module etc_top (
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire etc_pkg::etc_addr_t addr, // Register address
  input wire etc_pkg::etc_data_t wr_data, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output etc_pkg::etc_data_t rd_data, // Read data, cycle after strobe
  input wire logic timer_evt, // Timer event, on-chip
  input wire logic oc_out, // First output compare output, on-chip
  input wire logic trig_pin_a, // External trigger pin A
  input wire logic trig_pin_b, // External trigger pin B
  input wire logic cmp_out, // Comparator output, on-chip
  output logic edge_one_status, // Edge one has occurred
  output logic edge_two_status, // Edge two has occurred
  output logic irq // Level interrupt
);
  import etc_pkg::*;

  // ********************************************************************
  // Declarations
  // ********************************************************************
  etc_data_t cfg_q;
  logic st1_q;
  logic st2_q;
  logic st1_d;
  logic st2_d;
  etc_int_t istat_q;
  etc_int_t istat_d;
  etc_int_t imask_q;
  etc_int_t evt;
  etc_data_t rd_q;
  logic irq_q;
  logic [1:0] pins_s;
  logic wr_ctrl;
  logic wr_istat;
  logic wr_imask;

  etc_if eif [2] ();

  // Decodes a strobe against one register offset
  function automatic logic hit(input logic stb, input etc_addr_t a,
                               input etc_addr_t ofs);
    hit = stb && (a == ofs);
  endfunction

  assign wr_ctrl = hit(wr_en, addr, `ETC_CTRL_OFS);
  assign wr_istat = hit(wr_en, addr, `ETC_ISTAT_OFS);
  assign wr_imask = hit(wr_en, addr, `ETC_IMASK_OFS);

  // ********************************************************************
  // Source synchronisation
  // ********************************************************************
  // Only the pins are asynchronous; on-chip sources share clk
  etc_sync2 #(
    .W(2)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .d({trig_pin_b, trig_pin_a}),
    .q(pins_s)
  );

  // ********************************************************************
  // Edge channels
  // ********************************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ch
      localparam int MB = g ? `ETC_E2_MODE_BIT : `ETC_E1_MODE_BIT;
      localparam int PB = g ? `ETC_E2_POL_BIT : `ETC_E1_POL_BIT;
      localparam int SB = g ? `ETC_E2_SEL_LSB : `ETC_E1_SEL_LSB;
      localparam logic [3:0] MX = g ? `ETC_E2_MAX_SEL : `ETC_E1_MAX_SEL;

      assign eif[g].mode = cfg_q[MB];
      assign eif[g].pol = cfg_q[PB];
      assign eif[g].sel = cfg_q[SB +: 4];
      assign eif[g].src = {cmp_out, pins_s, oc_out, timer_evt};
      assign evt[g] = eif[g].evt;

      etc_edge_cond #(
        .MAX_SEL(MX)
      ) u_cond (
        .clk(clk),
        .rst(rst),
        .b(eif[g].cond)
      );
    end
  endgenerate

  // ********************************************************************
  // Control register
  // ********************************************************************
  // Status bits live in their own flops; bits 1-0 are never stored
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cfg_q <= `ETC_CTRL_RST;
    else if (wr_ctrl)
      cfg_q <= wr_data & `ETC_CFG_MASK;
  end

  // A hardware event wins over a software write of zero
  always_comb
  begin
    st1_d = wr_ctrl ? wr_data[`ETC_E1_STAT_BIT] : st1_q;
    st2_d = wr_ctrl ? wr_data[`ETC_E2_STAT_BIT] : st2_q;
    if (evt[0])
      st1_d = 1'b1;
    if (evt[1])
      st2_d = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st1_q <= 1'b0;
      st2_q <= 1'b0;
    end
    else
    begin
      st1_q <= st1_d;
      st2_q <= st2_d;
    end
  end

  assign edge_one_status = st1_q;
  assign edge_two_status = st2_q;

  // ********************************************************************
  // Interrupt status and mask
  // ********************************************************************
  // Write one to clear; a same-cycle event keeps its bit set
  always_comb
  begin
    istat_d = istat_q;
    if (wr_istat)
      istat_d = istat_q & ~wr_data[1:0];
    istat_d = istat_d | evt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      istat_q <= `ETC_INT_RST;
    else
      istat_q <= istat_d;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      imask_q <= `ETC_INT_RST;
    else if (wr_imask)
      imask_q <= wr_data[1:0];
  end

  // Registered so the output is glitch free; costs one cycle of latency
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= |(istat_q & imask_q);
  end

  assign irq = irq_q;

  // ********************************************************************
  // Read port
  // ********************************************************************
  // Data stand for exactly one cycle; unmapped reads return zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_q <= '0;
    else if (hit(rd_en, addr, `ETC_CTRL_OFS))
    begin
      rd_q <= cfg_q;
      rd_q[`ETC_E1_STAT_BIT] <= st1_q;
      rd_q[`ETC_E2_STAT_BIT] <= st2_q;
    end
    else if (hit(rd_en, addr, `ETC_ISTAT_OFS))
      rd_q <= {14'h0000, istat_q};
    else if (hit(rd_en, addr, `ETC_IMASK_OFS))
      rd_q <= {14'h0000, imask_q};
    else
      rd_q <= '0;
  end

  assign rd_data = rd_q;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_e1_pending;
    evt[0] && imask_q[0] && !wr_en ##1 !wr_en;
  endsequence

  sequence s_ctrl_write;
    wr_ctrl && !evt[1] ##1 1'b1;
  endsequence

  AST_E2_SET:
    assert property (evt[1] |=> edge_two_status)
      else $error("edge two event did not set its status");
  AST_E2_WRITE:
    assert property (s_ctrl_write |-> edge_two_status ==
                     $past(wr_data[`ETC_E2_STAT_BIT]))
      else $error("edge two status did not take written value");
  AST_E1_SET:
    assert property (evt[0] |=> edge_one_status [*1] ##0 istat_q[0])
      else $error("edge one event did not set its status");
  AST_E1_HOLD:
    assert property (!wr_ctrl && !evt[0] |=> $stable(edge_one_status))
      else $error("edge one status changed with no cause");
  AST_LOW_ZERO:
    assert property (hit(rd_en, addr, `ETC_CTRL_OFS) |=> rd_data[1:0] == 2'h0)
      else $error("unimplemented bits read nonzero");
  AST_E2_CFG:
    assert property (wr_ctrl |=> cfg_q[7:2] == $past(wr_data[7:2]))
      else $error("edge two configuration not stored");
  AST_E2_SEL_ROUTE:
    assert property (wr_ctrl |=> eif[1].sel == $past(wr_data[5:2]))
      else $error("edge two source field not routed");
  AST_E1_SEL_ROUTE:
    assert property (wr_ctrl |=> eif[0].sel == $past(wr_data[13:10]))
      else $error("edge one source field not routed");
  AST_E1_MODE:
    assert property (wr_ctrl |=> eif[0].mode == $past(wr_data[15])
                     && eif[0].pol == $past(wr_data[14]))
      else $error("edge one mode or polarity not routed");
  AST_IRQ:
    assert property (s_e1_pending |=> irq)
      else $error("unmasked edge one event raised no interrupt");
  AST_READ_ONCE:
    assert property (!rd_en |=> rd_data == 16'h0000)
      else $error("read data stood beyond its cycle");

  // ********************************************************************
  // Status, interrupt and register checks
  // ********************************************************************
  // A clear only shows when no event lands in the same cycle
  sequence s_e1_clear;
    wr_istat && wr_data[0] && !evt[0];
  endsequence

  sequence s_e2_clear;
    wr_istat && wr_data[1] && !evt[1];
  endsequence

  AST_E1_WRITE:
    assert property (wr_ctrl && !evt[0] |=> edge_one_status ==
                     $past(wr_data[`ETC_E1_STAT_BIT]))
      else $error("edge one status did not take written value");
  AST_E2_HOLD:
    assert property (!wr_ctrl && !evt[1] |=> $stable(edge_two_status))
      else $error("edge two status changed with no cause");
  AST_E2_ISTAT:
    assert property (evt[1] |=> istat_q[1])
      else $error("edge two event did not set interrupt status");
  AST_E1_CLEAR:
    assert property (s_e1_clear |=> !istat_q[0])
      else $error("edge one interrupt status not cleared");
  AST_E2_CLEAR:
    assert property (s_e2_clear |=> !istat_q[1])
      else $error("edge two interrupt status not cleared");
  AST_ISTAT_KEEP:
    assert property (!wr_istat |=>
                     (istat_q & $past(istat_q)) == $past(istat_q))
      else $error("interrupt status dropped without a clear");
  AST_IMASK_STORE:
    assert property (wr_imask |=> imask_q == $past(wr_data[1:0]))
      else $error("interrupt mask not stored");
  AST_IRQ_FOLLOW:
    assert property (1'b1 |=> irq == $past(|(istat_q & imask_q)))
      else $error("interrupt output does not follow pending bits");
  AST_IRQ_MASKED:
    assert property (imask_q == 2'h0 |=> !irq)
      else $error("masked interrupt reached the output");
  AST_RD_ISTAT:
    assert property (hit(rd_en, addr, `ETC_ISTAT_OFS) |=>
                     rd_data == {14'h0000, $past(istat_q)})
      else $error("interrupt status read back wrong");
  AST_RD_STATUS:
    assert property (hit(rd_en, addr, `ETC_CTRL_OFS) |=>
                     rd_data[9:8] == $past({st2_q, st1_q}))
      else $error("status bits read back wrong");
  AST_CFG_LOW:
    assert property (wr_ctrl |=> cfg_q[1:0] == 2'h0)
      else $error("unimplemented bits were stored");
endmodule

// ---- testbench/etc_src_model.sv ----
// Model of the on-chip edge sources and the two trigger pins
`timescale 1ns/1ps

module etc_src_model (
  input wire logic clk, // System clock
  output logic [4:0] src // Timer, compare, pin A, pin B, comparator
);
  // Index order follows the source codes 0000 to 0100
  initial src = 5'h00;

  // Levels move just after a rising edge, like the on-chip sources
  task automatic set_all(input logic v);
    @(posedge clk);
    src <= {5{v}};
  endtask

  task automatic set_one(input int i, input logic v);
    @(posedge clk);
    src[i] <= v;
  endtask
endmodule

// ---- testbench/tb_edge_trigger_control.sv ----
// Self-checking testbench of the edge trigger control block
`timescale 1ns/1ps
`include "etc_cfg.svh"

module tb_edge_trigger_control;
  import etc_pkg::*;
  logic clk;
  logic rst;
  etc_addr_t addr;
  etc_data_t wr_data;
  logic wr_en;
  logic rd_en;
  etc_data_t rd_data;
  logic [4:0] src;
  logic edge_one_status;
  logic edge_two_status;
  logic irq;
  int n_fail;
  int total_checks;

  etc_src_model etc_src_model_i (.clk(clk), .src(src));
  etc_top etc_top_i (.clk(clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .timer_evt(src[0]), .oc_out(src[1]), .trig_pin_a(src[2]),
    .trig_pin_b(src[3]), .cmp_out(src[4]),
    .edge_one_status(edge_one_status), .edge_two_status(edge_two_status),
    .irq(irq));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input etc_data_t got, input etc_data_t exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input etc_addr_t a, input etc_data_t d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input etc_addr_t a, output etc_data_t d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  function automatic etc_data_t st(input int ch);
    return {15'h0000, ch == 1 ? edge_one_status : edge_two_status};
  endfunction

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_st(input int ch);
    int k;
    k = 0;
    while (st(ch) !== 16'h0001 && k < 10)
    begin
      settle(1);
      k++;
    end
    // Judge by the bit itself, so a late set cannot end the run early
    if (st(ch) !== 16'h0001)
    begin
      chk(st(ch), 16'h0001);
      tally_and_finish();
    end
  endtask

  // Other channel gets a reserved source so it stays quiet
  function automatic etc_data_t cfg(input int ch, input logic [3:0] c,
                                    input logic m, input logic p);
    logic [7:0] f;
    f = {m, p, c, 2'b00};
    return ch == 1 ? {f, 8'h3C} : {8'h3C, f};
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic reset_regs;
    etc_data_t v;
    // Reset leaves both channels level-low on the timer, which idles low,
    // so both events fire at once; the first read still beats the status
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(i), v);
      chk(v, i == 1 ? 16'h0003 : 16'h0000);
    end
    wr(8'h03, 16'hFFFF);
    rd(8'h03, v);
    chk(v, 16'h0000);
  endtask

  task automatic reg_bits;
    etc_data_t v;
    wr(`ETC_CTRL_OFS, 16'hFFFF);
    rd(`ETC_CTRL_OFS, v);
    chk(v, 16'hFFFC);
    wr(`ETC_CTRL_OFS, 16'h3C3F);
    rd(`ETC_CTRL_OFS, v);
    chk(v, 16'h3C3C);
  endtask

  // Level-high sensing on reserved codes with every source high
  task automatic reserved_codes;
    etc_src_model_i.set_all(1'b1);
    for (int i = 0; i < 2; i++)
    begin
      wr(`ETC_CTRL_OFS, i ? 16'h607C : 16'h5054);
      settle(8);
      chk({edge_two_status, edge_one_status}, 16'h0000);
    end
  endtask

  task automatic run_chan(input int ch, input logic [3:0] c,
                          input logic m, input logic p);
    etc_data_t v;
    wr(`ETC_CTRL_OFS, 16'h3C3C);
    etc_src_model_i.set_all(m ? p : ~p);
    settle(6);
    wr(`ETC_CTRL_OFS, cfg(ch, c, m, p));
    rd(`ETC_CTRL_OFS, v);
    chk(v, cfg(ch, c, m, p));
    settle(4);
    chk(st(ch), 16'h0000);
    if (m)
    begin
      etc_src_model_i.set_one(c, ~p);
      settle(6);
      chk(st(ch), 16'h0000);
    end
    etc_src_model_i.set_one(c, p);
    wait_st(ch);
    chk(st(ch), 16'h0001);
    if (!m)
    begin
      // Clearing while the level still matches must set it again
      wr(`ETC_CTRL_OFS, cfg(ch, c, m, p));
      settle(6);
      chk(st(ch), 16'h0001);
    end
  endtask

  task automatic irq_flow;
    etc_data_t v;
    wr(`ETC_CTRL_OFS, 16'h3C3C);
    etc_src_model_i.set_all(1'b0);
    wr(`ETC_IMASK_OFS, 16'h0000);
    wr(`ETC_ISTAT_OFS, 16'h0003);
    wr(`ETC_CTRL_OFS, 16'hC03C);
    etc_src_model_i.set_one(0, 1'b1);
    wait_st(1);
    settle(3);
    chk({15'h0000, irq}, 16'h0000);
    rd(`ETC_ISTAT_OFS, v);
    chk(v, 16'h0001);
    rd(`ETC_CTRL_OFS, v);
    chk(v, 16'hC13C);
    wr(`ETC_IMASK_OFS, 16'h0001);
    settle(3);
    chk({15'h0000, irq}, 16'h0001);
    wr(`ETC_ISTAT_OFS, 16'h0001);
    settle(3);
    chk({15'h0000, irq}, 16'h0000);
    rd(`ETC_ISTAT_OFS, v);
    chk(v, 16'h0000);
  endtask

  // ****************************************
  // Clock and main sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    rst = 1'b1;
    addr = 8'h00;
    wr_data = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    reset_regs();
    reg_bits();
    reserved_codes();
    for (int k = 0; k < 16; k++)
      run_chan(1, 4'(k >> 2), k[1], k[0]);
    for (int k = 0; k < 20; k++)
      run_chan(2, 4'(k >> 2), k[1], k[0]);
    irq_flow();
    tally_and_finish();
  end
endmodule
